/* File: pkg/cafes_defs.svh */
// Purpose: Constants for the CAN acceptance filter and error status block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Offsets are chosen locally; nothing fixes them elsewhere
`ifndef CAFES_DEFS_SVH
`define CAFES_DEFS_SVH
`define CAFES_OFS_MISC      12'h000
`define CAFES_OFS_RXERR     12'h004
`define CAFES_OFS_TXERR     12'h008
`define CAFES_OFS_CTRL      12'h00c
`define CAFES_OFS_FILT      12'h010
`define CAFES_OFS_IRQ_STAT  12'h014
`define CAFES_OFS_IRQ_EN    12'h018
`define CAFES_OFS_IRQ_CLR   12'h01c
`define CAFES_OFS_CODE0     12'h020
`define CAFES_OFS_MASK0     12'h040
`define CAFES_BIT_HOLD      0
`define CAFES_BIT_BUSOFF_RECOVERY_OPTION      0
`define CAFES_BIT_INITIALIZATION_REQUEST    1
`define CAFES_BIT_SLEEP_REQUEST     2
`define CAFES_POS_MODE      4
`define CAFES_POS_HIT       0
`define CAFES_IRQ_ACCEPT    0
`define CAFES_IRQ_BUSOFF    1
`define CAFES_RST_BYTE      8'h00
`define CAFES_RST_CTRL      8'h00
`define CAFES_RST_MODE      2'h0
`endif

/* File: pkg/cafes_pkg.sv */
// Purpose: Types for the CAN acceptance filter and error status block
// Assumes: Constants live in cafes_defs.svh
// Notes:   Frame carrier holds the four identifier bytes and format
package cafes_pkg;
  typedef enum logic [1:0] {
    CAFES_MODE_32,
    CAFES_MODE_16,
    CAFES_MODE_8,
    CAFES_MODE_CLOSED
  } cafes_mode_t;

  typedef struct packed {
    logic [3:0][7:0] identifier_bytes; // Byte 0 in [7:0]
    logic            extended;         // Extended identifier frame
  } cafes_frame_t;

  typedef enum {
    CAFES_BO_ACTIVE,
    CAFES_BO_HOLD
  } cafes_bo_t;

  typedef struct packed {
    logic [7:0][7:0] accept_code;
    logic [7:0][7:0] accept_mask;
    logic [1:0]      filter_mode_select;
    logic [2:0]      filter_hit_index;
    logic            busoff_recovery_option;
    logic            initialization_request;
    logic            sleep_request;
    logic            busoff_hold_flag;
    logic [1:0]      irq_stat;
    logic [1:0]      irq_en;
    logic            rx_pending;
    logic [2:0]      bg_hit;
    logic            recover_pulse;
    logic [31:0]     prdata;
  } cafes_state_t;
endpackage

/* File: rtl/cafes_filter.sv */
// Purpose: Receive acceptance filter, bus-off hold flag and error counters
// Assumes: Frames arrive complete from the protocol engine, one per pulse
// Notes:   APB slave answers with zero wait states
`include "cafes_defs.svh"
`timescale 1ns/1ns
`default_nettype none

// Register map, one 32-bit word per register, byte lane 0 only:
//   0x00 misc_busoff_control
//        bit 0 hold flag; a one written clears it, a zero does nothing
//   0x04 receive_error_count
//        live copy of the engine's receive counter, writes dropped
//   0x08 transmit_error_count
//        live copy of the engine's transmit counter, writes dropped
//   0x0c control
//        bit 0 recovery option, bit 1 init request, bit 2 sleep request
//   0x10 filter control
//        bits 5:4 filter organisation (init mode writes only)
//        bits 2:0 hit index of the foreground frame, read-only
//   0x14 interrupt status
//        bit 0 accepted frame, bit 1 bus-off entry, sticky
//   0x18 interrupt enable, same layout as the status word
//   0x1c interrupt clear, write-only; a one clears the status bit
//   0x20 + 4n accept_code_n, n = 0..7 (init mode writes only)
//   0x40 + 4n accept_mask_n, n = 0..7 (init mode writes only)
// Everything else reads zero and ignores writes, except unaligned 0x20-0x5f addresses, which alias; no error response.
//
// Limitation: the counters are not gated by the mode, so a read
// outside acknowledged sleep or init mode may catch a moving value.
// Trade-off: read data is captured in the setup cycle so the access
// phase needs no wait state while prdata still comes from a flop.

// One acceptance byte; a mask one makes that bit don't care
module cafes_byte_match (
  input  wire logic [7:0] id_byte,   // Identifier byte
  input  wire logic [7:0] code_byte, // Acceptance code byte
  input  wire logic [7:0] mask_byte, // Acceptance mask byte
  output logic            match      // All cared bits equal
);
  assign match = &((~(id_byte ^ code_byte)) | mask_byte);
endmodule

// Behaviour
// - Writing one to the bus-off hold flag clears it and zero does nothing.
// - With the recovery option set, bus-off entry sets and holds the flag.
// - Clearing the hold flag is taken as the software recovery request.
// - The receive error counter is readable and ignores writes.
// - The transmit error counter is readable and ignores writes.
// - Every frame enters the background buffer; only accepted ones signal.
// - Identifier bytes are compared bit by bit with the code bytes.
// - In 32-bit mode extended frames use four byte pairs per bank, standard frames two.
// - Code and mask bytes read anytime and write only in init mode.
// - Each compare result is qualified by the matching mask bit.
// - Mask zero must match, mask one is don't care, all bits must match.
// - Mode field picks two 32, four 16, eight 8-bit filters, or closed.
// - The hit index names the accepting filter and loads with the frame.
module cafes_filter #(
  parameter int ADDR_W = 12 // APB address width
) (
  input  wire logic                  clock,          // 100 MHz clock
  input  wire logic                  rst,            // Sync reset, high
  input  wire logic                  clk_en,         // Freezes state if low
  input  wire logic                  psel,           // APB select
  input  wire logic                  penable,        // APB access phase
  input  wire logic                  pwrite,         // APB direction
  input  wire logic [ADDR_W-1:0]     paddr,          // APB byte address
  input  wire logic [31:0]           pwdata,         // APB write data
  input  wire logic [3:0]            pstrb,          // APB byte strobes
  output logic                       pready,         // APB ready
  output logic [31:0]                prdata,         // APB read data
  output logic                       pslverr,        // APB error
  input  wire logic                  frame_valid,    // Frame done, pulse
  input  wire cafes_pkg::cafes_frame_t frame_in,     // Received identifier
  input  wire logic                  fg_load,        // Frame to foreground
  input  wire logic                  busoff_enter,   // Bus-off entry pulse
  input  wire logic [7:0]            rx_err_count,   // Engine RX counter
  input  wire logic [7:0]            tx_err_count,   // Engine TX counter
  input  wire logic                  initialization_acknowledge, // Init ack
  input  wire logic                  sleep_acknowledge,          // Sleep ack
  output logic                       initialization_request,     // To core
  output logic                       sleep_request,              // To core
  output logic                       busoff_recovery_option,     // To core
  output logic                       busoff_hold,    // Stay bus-off
  output logic                       recovery_request, // Pulse to core
  output logic                       rx_accept,      // Accepted frame pulse
  output logic [2:0]                 rx_accept_hit,  // Hit of that frame
  output logic                       irq             // Level interrupt
);

  initial begin
    if (ADDR_W < 7) begin
      $error("ADDR_W too small for the register map");
    end
    // Offsets are 12-bit constants; wider buses only add zero bits
    if (ADDR_W > 32) begin
      $error("ADDR_W wider than the APB address");
    end
  end

  cafes_pkg::cafes_state_t r_reg;
  cafes_pkg::cafes_state_t r_next;

  logic        in_init;
  logic [7:0]  match_byte;
  logic        hit_any;
  logic [2:0]  hit_idx;
  logic        wr;
  logic        rd;
  logic [ADDR_W-1:0] ofs;
  logic [2:0]  sel;
  logic        bank_hit [0:7];
  logic [7:0]  pair_match;
  logic [7:0]  low_match;
  logic [31:0] rd_word;

  assign in_init = r_reg.initialization_request & initialization_acknowledge;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign ofs = paddr;
  assign sel = paddr[4:2];

  // bitwise compare, byte n against identifier byte n mod 4
  for (genvar g = 0; g < 8; g++) begin : g_full
    cafes_byte_match u_match (
      .id_byte   (frame_in.identifier_bytes[g % 4]),
      .code_byte (r_reg.accept_code[g]),
      .mask_byte (r_reg.accept_mask[g]),
      .match     (match_byte[g])
    );
  end

  // Byte pairs of the 16-bit filters see identifier bytes 0 and 1
  for (genvar g = 0; g < 8; g++) begin : g_pair
    cafes_byte_match u_match (
      .id_byte   (frame_in.identifier_bytes[g % 2]),
      .code_byte (r_reg.accept_code[g]),
      .mask_byte (r_reg.accept_mask[g]),
      .match     (pair_match[g])
    );
  end

  // Single-byte filters all see identifier byte 0
  for (genvar g = 0; g < 8; g++) begin : g_low
    cafes_byte_match u_match (
      .id_byte   (frame_in.identifier_bytes[0]),
      .code_byte (r_reg.accept_code[g]),
      .mask_byte (r_reg.accept_mask[g]),
      .match     (low_match[g])
    );
  end

  always_comb begin
    hit_any = 1'b0;
    hit_idx = 3'h0;
    for (int f = 0; f < 8; f++) begin
      bank_hit[f] = 1'b0;
    end
    case (cafes_pkg::cafes_mode_t'(r_reg.filter_mode_select))
      cafes_pkg::CAFES_MODE_32: begin
        for (int b = 0; b < 2; b++) begin
          if (frame_in.extended) begin
            bank_hit[b] = &match_byte[b*4 +: 4];
          end else begin
            bank_hit[b] = &match_byte[b*4 +: 2];
          end
        end
      end
      cafes_pkg::CAFES_MODE_16: begin
        // 16-bit filters look at identifier bytes 0 and 1
        for (int b = 0; b < 4; b++) begin
          bank_hit[b] = pair_match[b*2] & pair_match[b*2+1];
        end
      end
      cafes_pkg::CAFES_MODE_8: begin
        // 8-bit filters look at identifier byte 0 only
        for (int b = 0; b < 8; b++) begin
          bank_hit[b] = low_match[b];
        end
      end
      default: begin
        hit_any = 1'b0; // Closed: nothing accepted
      end
    endcase
    // Lowest numbered filter wins
    for (int f = 7; f >= 0; f--) begin
      if (bank_hit[f]) begin
        hit_any = 1'b1;
        hit_idx = 3'(f);
      end
    end
  end

  // State update, bus slave and event handling
  always_comb begin
    r_next = r_reg;
    r_next.recover_pulse = 1'b0;
    r_next.prdata = 32'h0000_0000;
    if (frame_valid) begin
      r_next.rx_pending = hit_any;
      r_next.bg_hit = hit_idx;
    end
    if (fg_load && r_reg.rx_pending) begin
      r_next.filter_hit_index = r_reg.bg_hit;
      r_next.rx_pending = frame_valid ? hit_any : 1'b0;
    end
    if (wr) begin
      case (ofs)
        `CAFES_OFS_MISC: begin
          if (pstrb[0] && pwdata[`CAFES_BIT_HOLD] && r_reg.busoff_hold_flag) begin
            r_next.busoff_hold_flag = 1'b0;
            r_next.recover_pulse = 1'b1;
          end
        end
        `CAFES_OFS_CTRL: begin
          if (pstrb[0]) begin
            r_next.busoff_recovery_option = pwdata[`CAFES_BIT_BUSOFF_RECOVERY_OPTION];
            r_next.initialization_request = pwdata[`CAFES_BIT_INITIALIZATION_REQUEST];
            r_next.sleep_request = pwdata[`CAFES_BIT_SLEEP_REQUEST];
          end
        end
        `CAFES_OFS_FILT: begin
          if (pstrb[0] && in_init) begin
            r_next.filter_mode_select = pwdata[`CAFES_POS_MODE +: 2];
          end
        end
        `CAFES_OFS_IRQ_EN: begin
          if (pstrb[0]) begin
            r_next.irq_en = pwdata[1:0];
          end
        end
        `CAFES_OFS_IRQ_CLR: begin
          if (pstrb[0]) begin
            r_next.irq_stat = r_reg.irq_stat & ~pwdata[1:0];
          end
        end
        default: begin
          if (in_init && pstrb[0] && ofs[ADDR_W-1:7] == '0) begin
            if (ofs[6:5] == 2'b01) begin
              r_next.accept_code[sel] = pwdata[7:0];
            end else if (ofs[6:5] == 2'b10) begin
              r_next.accept_mask[sel] = pwdata[7:0];
            end
          end
        end
      endcase
    end
    // hold on bus-off; set wins over clear
    if (busoff_enter && r_reg.busoff_recovery_option) begin
      r_next.busoff_hold_flag = 1'b1;
      r_next.recover_pulse = 1'b0;
    end
    if (frame_valid && hit_any) begin
      r_next.irq_stat[`CAFES_IRQ_ACCEPT] = 1'b1;
    end
    if (busoff_enter) begin
      r_next.irq_stat[`CAFES_IRQ_BUSOFF] = 1'b1;
    end
    // Read data is captured in the setup cycle
    if (psel && !penable && !pwrite) begin
      r_next.prdata = rd_word;
    end else if (rd) begin
      r_next.prdata = r_reg.prdata; // Hold through the access phase
    end
  end

  // Read mux; the counters pass through live, not snapshotted
  always_comb begin
    rd_word = 32'h0000_0000;
    case (ofs)
      `CAFES_OFS_MISC: begin
        rd_word = {31'h0, r_reg.busoff_hold_flag};
      end
      `CAFES_OFS_RXERR: begin
        rd_word = {24'h0, rx_err_count};
      end
      `CAFES_OFS_TXERR: begin
        rd_word = {24'h0, tx_err_count};
      end
      `CAFES_OFS_CTRL: begin
        rd_word = {29'h0, r_reg.sleep_request,
                   r_reg.initialization_request,
                   r_reg.busoff_recovery_option};
      end
      `CAFES_OFS_FILT: begin
        rd_word = {26'h0, r_reg.filter_mode_select,
                   1'b0, r_reg.filter_hit_index};
      end
      `CAFES_OFS_IRQ_STAT: begin
        rd_word = {30'h0, r_reg.irq_stat};
      end
      `CAFES_OFS_IRQ_EN: begin
        rd_word = {30'h0, r_reg.irq_en};
      end
      default: begin
        if (ofs[ADDR_W-1:7] == '0 && ofs[6:5] == 2'b01) begin
          rd_word = {24'h0, r_reg.accept_code[sel]};
        end else if (ofs[ADDR_W-1:7] == '0 && ofs[6:5] == 2'b10) begin
          rd_word = {24'h0, r_reg.accept_mask[sel]};
        end
      end
    endcase
  end

  // Single state register, frozen while clk_en is low
  always_ff @(posedge clock) begin
    if (rst) begin
      r_reg <= '0;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  // Handshake is combinational; data comes from flops
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = r_reg.prdata;
  assign initialization_request = r_reg.initialization_request;
  assign sleep_request = r_reg.sleep_request;
  assign busoff_recovery_option = r_reg.busoff_recovery_option;
  assign busoff_hold = r_reg.busoff_hold_flag;
  assign recovery_request = r_reg.recover_pulse;
  assign rx_accept = frame_valid & hit_any & clk_en;
  assign rx_accept_hit = hit_idx;
  assign irq = |(r_reg.irq_stat & r_reg.irq_en);

endmodule
`default_nettype wire

/* File: sim/cafes_filter_sva.sv */
// Purpose: Port assertions for the acceptance filter block
// Assumes: Zero wait APB; read data is loaded at the setup edge
// Notes:   The hold flag moves only on bus-off entry or a W1C write
`include "cafes_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module cafes_filter_sva #(
  parameter int ADDR_W = 12 // APB address width
) (
  input wire logic              clock,                  // Clock
  input wire logic              rst,                    // Reset
  input wire logic              clk_en,                 // Run enable
  input wire logic              psel,                   // APB select
  input wire logic              penable,                // APB access
  input wire logic              pwrite,                 // APB direction
  input wire logic [ADDR_W-1:0] paddr,                  // APB address
  input wire logic [31:0]       pwdata,                 // APB write data
  input wire logic [31:0]       prdata,                 // APB read data
  input wire logic              frame_valid,            // Frame pulse
  input wire logic              busoff_enter,           // Bus-off entry
  input wire logic [7:0]        rx_err_count,           // RX counter
  input wire logic [7:0]        tx_err_count,           // TX counter
  input wire logic              busoff_recovery_option, // Option bit
  input wire logic              busoff_hold,            // Hold flag
  input wire logic              recovery_request,       // Recovery pulse
  input wire logic              rx_accept               // Accept pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Access edge of a MISC write and setup edge of a read
  wire logic wr_misc = clk_en && psel && penable && pwrite
                       && paddr == `CAFES_OFS_MISC;
  wire logic rd_set = clk_en && psel && !penable && !pwrite;
  property p_hold_set;
    clk_en && busoff_enter && busoff_recovery_option |=> busoff_hold;
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("hold not set");
  property p_hold_clr;
    wr_misc && pwdata[0] && !busoff_enter |=> !busoff_hold;
  endproperty
  a_hold_clr: assert property (p_hold_clr) else $error("hold stuck");
  property p_hold_keep;
    busoff_hold && !(wr_misc && pwdata[0]) |=> busoff_hold;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("hold lost");
  property p_recover;
    wr_misc && pwdata[0] && busoff_hold && !busoff_enter
      |=> recovery_request;
  endproperty
  a_recover: assert property (p_recover) else $error("no recovery");
  property p_recov_src;
    recovery_request |-> $past(busoff_hold) && !busoff_hold;
  endproperty
  a_recov_src: assert property (p_recov_src) else $error("bad pulse");
  property p_rxerr;
    rd_set && paddr == `CAFES_OFS_RXERR
      |=> prdata[7:0] == $past(rx_err_count);
  endproperty
  a_rxerr: assert property (p_rxerr) else $error("rx count wrong");
  property p_txerr;
    rd_set && paddr == `CAFES_OFS_TXERR
      ##1 penable |-> prdata[7:0] == $past(tx_err_count);
  endproperty
  a_txerr: assert property (p_txerr) else $error("tx count wrong");
  property p_accept;
    rx_accept |-> frame_valid && clk_en;
  endproperty
  a_accept: assert property (p_accept) else $error("stray accept");
  c_accept: cover property (rx_accept);
  c_hold: cover property (busoff_hold);
  c_recover: cover property (recovery_request);
endmodule
bind cafes_filter cafes_filter_sva #(.ADDR_W(ADDR_W)) u_sva (.clock, .rst,
  .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .frame_valid,
  .busoff_enter, .rx_err_count, .tx_err_count, .busoff_recovery_option,
  .busoff_hold, .recovery_request, .rx_accept);
`default_nettype wire

/* File: sim/cafes_engine_model.sv */
// Purpose: Protocol engine stand-in on the far side of the filter
// Assumes: Bench calls drive once per cycle
// Notes:   Mode acknowledges lag their requests by one cycle
`timescale 1ns/1ns
`default_nettype none
module cafes_engine_model (
  input  wire logic                    clock,      // Clock
  input  wire logic                    init_req,   // Init request
  input  wire logic                    sleep_req,  // Sleep request
  output logic                         frame_valid = 1'b0, // Frame pulse
  output cafes_pkg::cafes_frame_t      frame_in = '0,      // Identifier
  output logic                         fg_load = 1'b0,     // To foreground
  output logic                         busoff_enter = 1'b0, // Bus-off
  output logic [7:0]                   rx_cnt = 8'h00,     // RX counter
  output logic [7:0]                   tx_cnt = 8'h00,     // TX counter
  output logic                         init_ack = 1'b0,    // Init ack
  output logic                         sleep_ack = 1'b0    // Sleep ack
);
  always @(posedge clock) begin
    init_ack <= init_req;
    sleep_ack <= sleep_req;
  end
  // Released identifier lines flip so stale data never looks valid
  task automatic drive(input logic fv, fl, bo,
                       input cafes_pkg::cafes_frame_t f);
    @(posedge clock);
    frame_valid <= fv;
    fg_load <= fl;
    busoff_enter <= bo;
    frame_in <= fv ? f : ~frame_in;
  endtask
  task automatic counts(input logic [7:0] r, t);
    @(posedge clock);
    rx_cnt <= r;
    tx_cnt <= t;
  endtask
endmodule
`default_nettype wire

/* File: sim/test_can_acceptance_filter_and_error_status.sv */
// Purpose: Register and filter tests for the acceptance filter block
// Assumes: Zero wait APB slave, byte addresses from cafes_defs.svh
// Notes:   Frames are sent outside init mode in every filter mode
`include "cafes_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module test_can_acceptance_filter_and_error_status;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] q;
  logic [7:0]  code_v [8];
  logic [7:0]  mask_v [8];
  logic [3:0]  e;
  logic [2:0]  last_hit;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc = 0;
  cafes_pkg::cafes_frame_t fr [4];
  wire logic [31:0] prdata;
  wire logic [7:0]  rxc, txc;
  wire logic [2:0]  rh;
  wire logic        pready, pe, fv, fl, bo, ia, sa, ir, sr, ra, irq;
  wire cafes_pkg::cafes_frame_t fi;
  cafes_filter uut (.clock(clock), .rst(rst), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pe),
    .frame_valid(fv), .frame_in(fi), .fg_load(fl), .busoff_enter(bo),
    .rx_err_count(rxc), .tx_err_count(txc), .initialization_acknowledge(ia),
    .sleep_acknowledge(sa), .initialization_request(ir), .sleep_request(sr),
    .busoff_recovery_option(), .busoff_hold(), .recovery_request(),
    .rx_accept(ra), .rx_accept_hit(rh), .irq(irq));
  cafes_engine_model model (.clock(clock), .init_req(ir), .sleep_req(sr),
    .frame_valid(fv), .frame_in(fi), .fg_load(fl), .busoff_enter(bo),
    .rx_cnt(rxc), .tx_cnt(txc), .init_ack(ia), .sleep_ack(sa));
  always #5 clock = ~clock;
  // Hang guard: the whole run needs well under 2000 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out;
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; held until pready is seen at a rising edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
    #1;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] x, string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q, x);
  endtask
  // Reference filter; scanning down lets the lowest hit win
  function automatic logic [3:0] exp_hit(int m, cafes_pkg::cafes_frame_t f);
    int nf, nk, st;
    logic ok;
    logic [3:0] r;
    r = 4'h0;
    nf = (m == 0) ? 2 : (m == 1) ? 4 : (m == 2) ? 8 : 0;
    st = (m == 0) ? 4 : (m == 1) ? 2 : 1;
    nk = (m == 0 && f.extended) ? 4 : (m == 2) ? 1 : 2;
    for (int b = nf - 1; b >= 0; b--) begin
      ok = 1'b1;
      for (int k = 0; k < nk; k++)
        ok &= ((f.identifier_bytes[k] ^ code_v[b*st+k])
              & ~mask_v[b*st+k]) == 8'h00;
      if (ok) r = {1'b1, 3'(b)};
    end
    return r;
  endfunction
  // Main sequence: registers, filters, interrupt, bus-off hold
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(`CAFES_OFS_FILT, 32'h0, "filt reset");
    rd(12'h100, 32'h0, "unmapped");
    chk("slverr", pe, 1'b0);
    model.counts(8'h5a, 8'ha5);
    wr(`CAFES_OFS_CTRL, 32'h4);
    repeat (2) @(posedge clock);
    rd(`CAFES_OFS_RXERR, 32'h5a, "rx count");
    wr(`CAFES_OFS_RXERR, 32'hff);
    rd(`CAFES_OFS_RXERR, 32'h5a, "rx count ro");
    wr(`CAFES_OFS_TXERR, 32'hff);
    rd(`CAFES_OFS_TXERR, 32'ha5, "tx count");
    wr(`CAFES_OFS_CODE0, 32'h3c);
    rd(`CAFES_OFS_CODE0, 32'h0, "code locked");
    wr(`CAFES_OFS_CTRL, 32'h2);
    repeat (2) @(posedge clock);
    for (int n = 0; n < 8; n++) begin
      code_v[n] = 8'h21 + 8'h12 * 8'(n);
      mask_v[n] = n[0] ? 8'h07 : 8'h00;
      wr(`CAFES_OFS_CODE0 + 12'(4 * n), {24'h0, code_v[n]});
      wr(`CAFES_OFS_MASK0 + 12'(4 * n), {24'h0, mask_v[n]});
    end
    rd(`CAFES_OFS_MASK0 + 12'h01c, 32'h7, "mask7");
    fr[0] = {code_v[3], code_v[2], code_v[1], code_v[0], 1'b1};
    fr[1] = {16'h0, code_v[5] ^ 8'h05, code_v[4], 1'b0};
    fr[2] = {code_v[3], code_v[2] ^ 8'h40, code_v[1], code_v[0], 1'b1};
    fr[3] = {24'h0, code_v[6], 1'b1};
    last_hit = 3'h0;
    for (int m = 0; m < 4; m++) begin
      wr(`CAFES_OFS_CTRL, 32'h2);
      repeat (2) @(posedge clock);
      wr(`CAFES_OFS_FILT, 32'(m) << 4);
      wr(`CAFES_OFS_CTRL, 32'h0);
      for (int f = 0; f < 4; f++) begin
        e = exp_hit(m, fr[f]);
        model.drive(1'b1, 1'b0, 1'b0, fr[f]);
        #1;
        chk("accept", ra, e[3]);
        if (e[3]) chk("hit", rh, e[2:0]);
        if (e[3]) last_hit = e[2:0];
        model.drive(1'b0, 1'b1, 1'b0, fr[f]);
        model.drive(1'b0, 1'b0, 1'b0, fr[f]);
        rd(`CAFES_OFS_FILT, (32'(m) << 4) | last_hit, "filt");
      end
    end
    chk("irq masked", irq, 1'b0);
    wr(`CAFES_OFS_IRQ_EN, 32'h1);
    chk("irq on", irq, 1'b1);
    wr(`CAFES_OFS_IRQ_CLR, 32'h1);
    chk("irq cleared", irq, 1'b0);
    model.drive(1'b0, 1'b0, 1'b1, fr[0]);
    model.drive(1'b0, 1'b0, 1'b0, fr[0]);
    rd(`CAFES_OFS_MISC, 32'h0, "no option");
    wr(`CAFES_OFS_CTRL, 32'h1);
    model.drive(1'b0, 1'b0, 1'b1, fr[0]);
    model.drive(1'b0, 1'b0, 1'b0, fr[0]);
    rd(`CAFES_OFS_MISC, 32'h1, "hold set");
    rd(`CAFES_OFS_IRQ_STAT, 32'h2, "irq stat");
    wr(`CAFES_OFS_MISC, 32'h0);
    rd(`CAFES_OFS_MISC, 32'h1, "hold kept");
    wr(`CAFES_OFS_MISC, 32'h1);
    rd(`CAFES_OFS_MISC, 32'h0, "hold cleared");
    close_out();
  end
endmodule
`default_nettype wire
